// [smd_pkg.sv]
// Constants shared by the shared memory display port.
// Assumes a 40 MHz system clock and a link clock supplied from outside.
package smd_pkg;

  localparam int unsigned LINE_BITS   = 128;
  localparam int unsigned LINE_COUNT  = 128;
  localparam int unsigned LADDR_BITS  = 7;
  localparam int unsigned HDR_BITS    = 8;
  localparam int unsigned FRAME_BITS  = HDR_BITS + LINE_BITS;
  localparam int unsigned CNT_BITS    = 8;
  localparam logic [CNT_BITS-1:0] CNT_LAST = 8'h87;
  localparam logic [CNT_BITS-1:0] CNT_RST  = 8'h00;

  localparam int unsigned MCLK_HZ       = 40_000_000;
  localparam int unsigned COM_TIMEOUT_MS = 1000;
  localparam int unsigned COM_TIMEOUT_CYC = COM_TIMEOUT_MS * (MCLK_HZ / 1000);
  localparam int unsigned TMR_BITS      = 32;

  localparam logic [LINE_BITS-1:0]  LINE_RST = 128'h0;
  localparam logic [LADDR_BITS-1:0] ADDR_RST = 7'h00;

endpackage

// [smd_display_port.sv]
// Display-side logic of the shared memory display port: serial line intake,
// pixel memory, ownership and common-inversion supervision.
// Assumes the link clock runs only while display_select is high and that all
// pin inputs are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R1) Application owns the display only while display_owner_select is high.
// (R2) Serial data shifts in only while display_select is high, on the supplied clock.
// (R3) The driver keeps the serial clock at or below 1.1 MHz; smd_link_drv clocks it at 12.5 MHz.
// (R4) Transfers are whole 128-bit lines; no single pixel writes.
// (R5) Pixel array is 128 lines by 128 one-bit pixels.
// (R6) Written lines are held in the pixels without any refresh.
// (R7) The owner pulses the common inversion line periodically while in control.
// (R8) A non-owner holds select low and leaves data, clock and inversion undriven; smd_link_drv always drives all four, and t_owner sends a frame.
module smd_display_port
  import smd_pkg::*;
#(
  parameter int unsigned COM_TIMEOUT = COM_TIMEOUT_CYC
)
(
  // System clock and reset.
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Link pins.
  input  wire logic                  display_serial_clock,
  input  wire logic                  display_select,
  input  wire logic                  display_serial_in,
  input  wire logic                  display_owner_select,
  input  wire logic                  common_inversion_pulse,
  // Panel scan read port.
  input  wire logic [LADDR_BITS-1:0] scan_line,
  output logic      [LINE_BITS-1:0]  scan_data,
  // Status.
  output logic                       line_written,
  output logic      [LADDR_BITS-1:0] last_line,
  output logic                       app_owned,
  output logic                       com_polarity,
  output logic                       com_stale
);

  // ************************************************************
  // Link domain.
  // ************************************************************
  logic                   link_clr_reg;
  logic [CNT_BITS-1:0]    bit_cnt_reg;
  logic [FRAME_BITS-2:0]  shift_reg;
  logic [LINE_BITS-1:0]   hold_line_reg;
  logic [LADDR_BITS-1:0]  hold_addr_reg;
  logic                   done_tgl_reg;
  logic                   frame_end;

  // The last bit of a frame is the one that completes a line.
  assign frame_end = display_select && (bit_cnt_reg == CNT_LAST);

  // The bit counter is cleared by the frame's own select, since the link
  // clock stops between frames and cannot be relied on to end a frame.
  always_ff @(posedge display_serial_clock or negedge display_select)
  begin
    if (!display_select)
      bit_cnt_reg <= CNT_RST;
    else if (bit_cnt_reg == CNT_LAST)
      bit_cnt_reg <= CNT_RST; // [R4]
    else
      bit_cnt_reg <= bit_cnt_reg + 8'h01; // [R2]
  end

  always_ff @(posedge display_serial_clock)
  begin
    if (display_select)
      shift_reg <= {shift_reg[FRAME_BITS-3:0], display_serial_in}; // [R2]
  end

  // A whole line is latched only when its last bit arrives; a truncated
  // frame is dropped, so no partial line reaches the pixels.
  always_ff @(posedge display_serial_clock)
  begin
    if (frame_end)
    begin
      hold_line_reg <= {shift_reg[LINE_BITS-2:0], display_serial_in}; // [R4]
      hold_addr_reg <= shift_reg[FRAME_BITS-3:LINE_BITS-1];
    end
  end

  always_ff @(posedge display_serial_clock or posedge link_clr_reg)
  begin
    if (link_clr_reg)
      done_tgl_reg <= 1'b0;
    else if (frame_end)
      done_tgl_reg <= ~done_tgl_reg;
  end

  // ************************************************************
  // Synchronisers.
  // ************************************************************
  logic [2:0] tgl_sync_reg;
  logic [1:0] own_sync_reg;
  logic [2:0] com_sync_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      link_clr_reg <= 1'b1;
    else
      link_clr_reg <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tgl_sync_reg <= 3'h0;
    else
      tgl_sync_reg <= {tgl_sync_reg[1:0], done_tgl_reg};
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      own_sync_reg <= 2'h0;
    else
      own_sync_reg <= {own_sync_reg[0], display_owner_select}; // [R1]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      com_sync_reg <= 3'h0;
    else
      com_sync_reg <= {com_sync_reg[1:0], common_inversion_pulse};
  end

  logic line_commit;
  logic com_rise;
  logic commit_ok;

  assign line_commit = tgl_sync_reg[2] ^ tgl_sync_reg[1];
  assign com_rise    = com_sync_reg[1] & ~com_sync_reg[2];
  // Ownership is judged when the line lands, not when its frame began.
  assign commit_ok   = line_commit && own_sync_reg[1]; // [R1]

  // ************************************************************
  // Pixel memory.
  // ************************************************************
  logic [LINE_BITS-1:0] pixel_mem [LINE_COUNT]; // [R5]

  // The holding word stays stable for a full frame after the toggle, far
  // longer than the three mclk cycles the crossing takes.
  always_ff @(posedge mclk)
  begin
    if (commit_ok)
      pixel_mem[hold_addr_reg] <= hold_line_reg; // [R6] [R1]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      scan_data <= LINE_RST;
    else
      scan_data <= pixel_mem[scan_line]; // [R6]
  end

  // ************************************************************
  // Status.
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      line_written <= 1'b0;
    else
      line_written <= commit_ok; // [R4]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      last_line <= ADDR_RST;
    else if (commit_ok)
      last_line <= hold_addr_reg; // [R5]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      app_owned <= 1'b0;
    else
      app_owned <= own_sync_reg[1]; // [R1]
  end

  // ************************************************************
  // Common inversion supervision.
  // ************************************************************
  logic [TMR_BITS-1:0] com_tmr_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      com_polarity <= 1'b0;
    else if (com_rise)
      com_polarity <= ~com_polarity; // [R7]
  end

  // The timer only warns; the panel cannot force the owner to pulse.
  always_ff @(posedge mclk)
  begin
    if (!rst_n || com_rise || !own_sync_reg[1])
      com_tmr_reg <= '0;
    else if (com_tmr_reg != TMR_BITS'(COM_TIMEOUT))
      com_tmr_reg <= com_tmr_reg + 32'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      com_stale <= 1'b0;
    else
      com_stale <= own_sync_reg[1] && (com_tmr_reg == TMR_BITS'(COM_TIMEOUT)); // [R7]
  end

endmodule

`default_nettype wire

// [smd_port_chk.sv]
// Checker of the display port status outputs against their causes.
// Assumes it is bound to smd_display_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module smd_port_chk
  import smd_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  line_written,
  input wire logic                  app_owned,
  input wire logic                  com_polarity,
  input wire logic                  com_stale,
  input wire logic                  common_inversion_pulse,
  input wire logic [LADDR_BITS-1:0] last_line
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  pulse_single_a: assert property (line_written |=> !line_written [*8])
    else $error("line pulse too long");
  owner_gate_a: assert property (line_written |-> app_owned)
    else $error("line taken while not owned");
  addr_hold_a: assert property ($changed(last_line) |-> line_written)
    else $error("line address moved without a commit");
  com_flip_a: assert property ($changed(com_polarity) |-> $past(common_inversion_pulse, 3))
    else $error("polarity moved without a pulse");
  stale_owner_a: assert property (com_stale |-> app_owned)
    else $error("stale warning while not owned");
endmodule
bind smd_display_port smd_port_chk chk_u (.mclk, .rst_n, .line_written, .app_owned,
  .com_polarity, .com_stale, .common_inversion_pulse, .last_line);
`default_nettype wire

// [smd_link_drv.sv]
// Model of the application driving the display link.
// Assumes the bench calls send and pulse from its main sequence.
`timescale 1ns/1ps
`default_nettype none
module smd_link_drv
(
  output logic display_serial_clock,
  output logic display_select,
  output logic display_serial_in,
  output logic common_inversion_pulse
);
  // The link starts idle with select low and the clock still; send does not look at ownership.
  initial
  begin
    display_serial_clock   = 1'b0;
    display_select         = 1'b0;
    display_serial_in      = 1'b0;
    common_inversion_pulse = 1'b0;
  end
  // The clock runs only inside a frame; the data line then shows the inverse of its last bit.
  // The bench shifts far faster than a real panel accepts, to keep runs short.
  task automatic send(input logic [6:0] a, input logic [127:0] d, input int n);
    logic [135:0] f;
    f = {1'b0, a, d};
    #7 display_select = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      display_serial_in = f[135-i];
      #40 display_serial_clock = 1'b1;
      #40 display_serial_clock = 1'b0;
    end
    #40 display_select = 1'b0;
    display_serial_in = ~display_serial_in;
  endtask
  task automatic pulse();
    common_inversion_pulse = 1'b1;
    #500 common_inversion_pulse = 1'b0;
  endtask
endmodule
`default_nettype wire

// [smd_display_port_tb_top.sv]
// Bench for the display port: line frames, ownership and inversion.
// Assumes the link model smd_link_drv drives the link pins except display_owner_select, which the bench drives.
`timescale 1ns/1ps
`default_nettype none
module smd_display_port_tb_top;
  import smd_pkg::*;
  localparam logic [127:0] P1 = 128'h8001_F00F_1234_5678_9ABC_DEF0_0FF0_C3A5;
  logic mclk = 0, rst_n = 0, display_owner_select = 0;
  logic [6:0] scan_line = '0, last_line;
  logic [127:0] scan_data;
  logic line_written, app_owned, com_polarity, com_stale;
  wire display_serial_clock, display_select, display_serial_in, common_inversion_pulse;
  int fail_count = 0, cmp_count = 0, wr_cnt = 0, cyc = 0;
  smd_link_drv drv_u (.display_serial_clock, .display_select, .display_serial_in,
    .common_inversion_pulse);
  smd_display_port #(.COM_TIMEOUT(50)) dut_u (.mclk, .rst_n, .display_serial_clock,
    .display_select, .display_serial_in, .display_owner_select, .common_inversion_pulse,
    .scan_line, .scan_data, .line_written, .last_line, .app_owned, .com_polarity, .com_stale);
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (line_written === 1'b1) wr_cnt <= wr_cnt + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(string n, logic [127:0] e, logic [127:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic line(logic [6:0] a, logic [127:0] d, int n, int w);
    int c0;
    c0 = wr_cnt;
    drv_u.send(a, d, n);
    repeat (12) @(negedge mclk);
    chk("pulses", 128'(w), 128'(wr_cnt - c0));
  endtask
  task automatic peek(logic [6:0] a, logic [127:0] d);
    scan_line = a;
    repeat (2) @(negedge mclk);
    chk("line", d, scan_data);
  endtask
  task automatic t_write();
    display_owner_select = 1;
    repeat (4) @(negedge mclk);
    chk("owned", 1, app_owned);
    line(7'h05, P1, 136, 1);
    chk("last", 128'(7'h05), 128'(last_line));
    line(7'h7F, ~P1, 136, 1);
    peek(7'h7F, ~P1);
    peek(7'h05, P1);
  endtask
  task automatic t_partial();
    line(7'h09, P1, 100, 0);
    chk("last", 128'(7'h7F), 128'(last_line));
  endtask
  task automatic t_owner();
    display_owner_select = 0;
    repeat (4) @(negedge mclk);
    chk("owned", 0, app_owned);
    chk("stale", 0, com_stale);
    line(7'h05, ~P1, 136, 0);
    peek(7'h05, P1);
    display_owner_select = 1;
  endtask
  task automatic t_com();
    repeat (80) @(negedge mclk);
    chk("stale", 1, com_stale);
    drv_u.pulse();
    repeat (6) @(negedge mclk);
    chk("polarity", 1, com_polarity);
    chk("stale", 0, com_stale);
    drv_u.pulse();
    repeat (6) @(negedge mclk);
    chk("polarity", 0, com_polarity);
  endtask
  initial
  begin
    repeat (10) @(negedge mclk);
    rst_n = 1;
    repeat (2) @(negedge mclk);
    t_write();
    t_partial();
    t_owner();
    t_com();
    stop_test();
  end
endmodule
`default_nettype wire
